// ---- pov_map.svh ----
// Register offsets, field positions and reset values of the override stage
`ifndef POV_MAP_SVH
`define POV_MAP_SVH

// Byte offsets inside the block's window
`define POV_ADDR_W 8
`define POV_CTRL_OFS 8'h00
`define POV_PINS_OFS 8'h04
`define POV_INFO_OFS 8'h08

// Control register layout
`define POV_REG_W 16
`define POV_FIELD_W 6
`define POV_SEL_LSB 8
`define POV_OUT_LSB 0
`define POV_CTRL_RST 16'h3F00
`define POV_CTRL_MASK 16'h3F3F

// Pin state register layout
`define POV_PINS_HI_LSB 8
`define POV_PINS_LO_LSB 0

// Info register layout
`define POV_INFO_PAIRS_LSB 0

`endif

// ---- pov_pkg.sv ----
// Shared types of the output override stage
package pov_pkg;

    typedef logic [15:0] pov_reg_t;

    typedef enum logic [1:0] {
        POV_TRANS_IDLE = 2'h0,
        POV_TRANS_BUSY = 2'h1,
        POV_TRANS_NONSEQ = 2'h2,
        POV_TRANS_SEQ = 2'h3
    } pov_htrans_e;

    typedef enum logic [2:0] {
        POV_SIZE_BYTE = 3'h0,
        POV_SIZE_HALF = 3'h1,
        POV_SIZE_WORD = 3'h2
    } pov_hsize_e;

endpackage

// ---- pov_ahb_front.sv ----
// AHB-Lite address phase capture for the override stage
`include "pov_map.svh"

module pov_ahb_front (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Address phase
    input wire logic hsel,
    input wire logic [`POV_ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    // Decoded request
    output logic rd_take,
    output logic wr_pend_q,
    output logic [`POV_ADDR_W-1:0] wr_addr_q,
    output logic [3:0] wr_be_q
);

    logic take;
    logic [3:0] be;
    logic wr_pend_d;
    logic [`POV_ADDR_W-1:0] wr_addr_d;
    logic [3:0] wr_be_d;

    // Byte lanes from size and low address bits
    always_comb begin
        unique case (hsize)
            pov_pkg::POV_SIZE_BYTE: be = 4'h1 << haddr[1:0];
            pov_pkg::POV_SIZE_HALF: be = haddr[1] ? 4'hC : 4'h3;
            default: be = 4'hF;
        endcase
    end

    assign take = hsel && hready && htrans[1];
    assign rd_take = take && !hwrite;

    always_comb begin
        wr_pend_d = wr_pend_q;
        wr_addr_d = wr_addr_q;
        wr_be_d = wr_be_q;
        if (hready) begin
            wr_pend_d = take && hwrite;
            if (take && hwrite) begin
                wr_addr_d = {haddr[`POV_ADDR_W-1:2], 2'h0};
                wr_be_d = be;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            wr_be_q <= 4'h0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            wr_be_q <= wr_be_d;
        end
    end

endmodule

// ---- pov_pin_pair.sv ----
// Pin drive of one complementary pair: generator waveform or manual level
module pov_pin_pair #(
    parameter bit HIGH_ACTIVE_LEVEL = 1'b1,
    parameter bit LOW_ACTIVE_LEVEL = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic high_pin_generator_select,
    input wire logic low_pin_generator_select,
    input wire logic high_pin_manual_level,
    input wire logic low_pin_manual_level,
    // Generator waveform
    input wire logic gen_high,
    input wire logic gen_low,
    // Pins
    output logic pair_high_output_pin_q,
    output logic pair_low_output_pin_q
);

    logic high_d;
    logic low_d;

    always_comb begin
        if (high_pin_generator_select) begin
            high_d = gen_high;
        end else begin
            high_d = high_pin_manual_level ? HIGH_ACTIVE_LEVEL : !HIGH_ACTIVE_LEVEL;
        end
        if (low_pin_generator_select) begin
            low_d = gen_low;
        end else begin
            low_d = low_pin_manual_level ? LOW_ACTIVE_LEVEL : !LOW_ACTIVE_LEVEL;
        end
    end

    // Reset level equals inactive level until the first generator sample
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pair_high_output_pin_q <= !HIGH_ACTIVE_LEVEL;
            pair_low_output_pin_q <= !LOW_ACTIVE_LEVEL;
        end else begin
            pair_high_output_pin_q <= high_d;
            pair_low_output_pin_q <= low_d;
        end
    end

endmodule

// ---- pov_top.sv ----
// Output override stage of a motor PWM unit with AHB-Lite register access
//
// Operation
// - Select bit set: generator waveform passes unchanged
// - Select bit clear: manual bit drives pin
// - Manual 1 drives active, 0 inactive
// - Selects in bits 13-8, manual 5-0
// - Reset: selects all 1, manual all 0
// - Second instance: only pair 1 works
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`include "pov_map.svh"

module pov_top #(
    parameter int NUM_PAIRS = 3,
    parameter logic [2:0] HIGH_ACTIVE_LEVEL = 3'h7,
    parameter logic [2:0] LOW_ACTIVE_LEVEL = 3'h7
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // Generator waveform, index 0 is pair 1
    input wire logic [2:0] GEN_HIGH,
    input wire logic [2:0] GEN_LOW,
    // Pin drive
    output logic [2:0] PAIR_HIGH_OUTPUT_PIN,
    output logic [2:0] PAIR_LOW_OUTPUT_PIN
);

    logic rd_take;
    logic wr_pend_q;
    logic [`POV_ADDR_W-1:0] wr_addr_q;
    logic [3:0] wr_be_q;
    pov_pkg::pov_reg_t ctrl_q;
    pov_pkg::pov_reg_t ctrl_d;
    pov_pkg::pov_reg_t impl_mask;
    pov_pkg::pov_reg_t wr_mask;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic [31:0] pins_word;
    logic [31:0] info_word;

    pov_ahb_front u_front (
        .clk(MCLK),
        .rst_n(RESETN),
        .hsel(HSEL),
        .haddr(HADDR[`POV_ADDR_W-1:0]),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hsize(HSIZE),
        .hready(HREADY),
        .rd_take(rd_take),
        .wr_pend_q(wr_pend_q),
        .wr_addr_q(wr_addr_q),
        .wr_be_q(wr_be_q)
    );

    // Writable bits: only fields of pairs that exist
    always_comb begin
        impl_mask = '0;
        for (int p = 0; p < 3; p++) begin
            if (p < NUM_PAIRS) begin
                impl_mask[`POV_SEL_LSB + 2 * p] = 1'b1;
                impl_mask[`POV_SEL_LSB + 2 * p + 1] = 1'b1;
                impl_mask[`POV_OUT_LSB + 2 * p] = 1'b1;
                impl_mask[`POV_OUT_LSB + 2 * p + 1] = 1'b1;
            end
        end
        impl_mask = impl_mask & `POV_CTRL_MASK;
        wr_mask = {{8{wr_be_q[1]}}, {8{wr_be_q[0]}}} & impl_mask;
    end

    // Register write in the data phase
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_pend_q && (wr_addr_q == `POV_CTRL_OFS)) begin
            ctrl_d = (ctrl_q & ~wr_mask) | (HWDATA[`POV_REG_W-1:0] & wr_mask);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            ctrl_q <= `POV_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Pin pairs, index p drives pair p+1
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pair
            if (g < NUM_PAIRS) begin : g_on
                pov_pin_pair #(
                    .HIGH_ACTIVE_LEVEL(HIGH_ACTIVE_LEVEL[g]),
                    .LOW_ACTIVE_LEVEL(LOW_ACTIVE_LEVEL[g])
                ) u_pair (
                    .clk(MCLK),
                    .rst_n(RESETN),
                    .high_pin_generator_select(ctrl_q[`POV_SEL_LSB + 2 * g + 1]),
                    .low_pin_generator_select(ctrl_q[`POV_SEL_LSB + 2 * g]),
                    .high_pin_manual_level(ctrl_q[`POV_OUT_LSB + 2 * g + 1]),
                    .low_pin_manual_level(ctrl_q[`POV_OUT_LSB + 2 * g]),
                    .gen_high(GEN_HIGH[g]),
                    .gen_low(GEN_LOW[g]),
                    .pair_high_output_pin_q(PAIR_HIGH_OUTPUT_PIN[g]),
                    .pair_low_output_pin_q(PAIR_LOW_OUTPUT_PIN[g])
                );
            end else begin : g_off
                // Absent pair held at its inactive level
                assign PAIR_HIGH_OUTPUT_PIN[g] = !HIGH_ACTIVE_LEVEL[g];
                assign PAIR_LOW_OUTPUT_PIN[g] = !LOW_ACTIVE_LEVEL[g];
            end
        end
    endgenerate

    // Read words
    always_comb begin
        pins_word = '0;
        pins_word[`POV_PINS_HI_LSB +: 3] = PAIR_HIGH_OUTPUT_PIN;
        pins_word[`POV_PINS_LO_LSB +: 3] = PAIR_LOW_OUTPUT_PIN;
        info_word = '0;
        info_word[`POV_INFO_PAIRS_LSB +: 2] = 2'(NUM_PAIRS);
    end

    // Read data captured at the address phase; uses ctrl_d so a write just ahead is seen
    always_comb begin
        hrdata_d = hrdata_q;
        if (rd_take) begin
            unique case ({HADDR[`POV_ADDR_W-1:2], 2'h0})
                `POV_CTRL_OFS: hrdata_d = {16'h0000, ctrl_d & impl_mask};
                `POV_PINS_OFS: hrdata_d = pins_word;
                `POV_INFO_OFS: hrdata_d = info_word;
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            hrdata_q <= 32'h0000_0000;
        end else begin
            hrdata_q <= hrdata_d;
        end
    end

    // Zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_q;

endmodule

// ---- pov_gate_drv.sv ----
// Gate driver model on the far side of the pins
module pov_gate_drv (
    // Clock
    input wire logic clk,
    // Pin levels
    input wire logic [2:0] high_in,
    input wire logic [2:0] low_in,
    // Gate state
    output logic [5:0] gate_q
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk) begin
        gate_q <= {high_in, low_in};
    end
endmodule

// ---- pov_top_chk.sv ----
// Assertions on the override stage ports
module pov_top_chk #(
    parameter int NUM_PAIRS = 3
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    // Pins
    input wire logic [2:0] GEN_HIGH,
    input wire logic [2:0] GEN_LOW,
    input wire logic [2:0] PAIR_HIGH_OUTPUT_PIN,
    input wire logic [2:0] PAIR_LOW_OUTPUT_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] LIVE = 6'((1 << (2 * NUM_PAIRS)) - 1);
    logic wr_pend_q;
    logic [15:0] ctl_q;
    logic [5:0] gen6;
    logic [5:0] pin6;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    assign gen6 = {GEN_HIGH[2], GEN_LOW[2], GEN_HIGH[1], GEN_LOW[1], GEN_HIGH[0], GEN_LOW[0]};
    assign pin6 = {PAIR_HIGH_OUTPUT_PIN[2], PAIR_LOW_OUTPUT_PIN[2], PAIR_HIGH_OUTPUT_PIN[1],
        PAIR_LOW_OUTPUT_PIN[1], PAIR_HIGH_OUTPUT_PIN[0], PAIR_LOW_OUTPUT_PIN[0]};
    // Shadow of the control register
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            wr_pend_q <= 1'b0;
            ctl_q <= {2'h0, LIVE, 8'h00};
        end else begin
            wr_pend_q <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == 8'h00;
            if (wr_pend_q) begin
                ctl_q <= HWDATA[15:0] & {2'h0, LIVE, 2'h0, LIVE};
            end
        end
    end
    sequence rd_ctl_s;
        HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == 8'h00;
    endsequence
    sequence wr_ctl_s;
        HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == 8'h00;
    endsequence
    read_back_a: assert property (rd_ctl_s |=> HRDATA[15:0] == ctl_q)
        else $error("control readback wrong");
    reserved_zero_a: assert property (HRDATA[15:14] == 2'h0 && HRDATA[7:6] == 2'h0)
        else $error("reserved bits not zero");
    reset_pins_a: assert property (RESETN && !$past(RESETN) |-> pin6 == 6'h00)
        else $error("pins active after reset");
    for (genvar i = 0; i < 6; i++) begin : g_pin
        if (i < 2 * NUM_PAIRS) begin : g_live
            gen_pass_a: assert property ($past(RESETN) && $past(ctl_q[8 + i])
                |-> pin6[i] == $past(gen6[i])) else $error("pin not from generator");
            manual_drive_a: assert property ($past(RESETN) && !$past(ctl_q[8 + i])
                |-> pin6[i] == $past(ctl_q[i])) else $error("pin not from manual bit");
            manual_level_a: assert property ((wr_ctl_s ##1 (!HWDATA[8 + i] && HWDATA[i]))
                |-> ##2 pin6[i]) else $error("manual one not active");
        end else begin : g_dead
            absent_pair_a: assert property (pin6[i] == 1'b0)
                else $error("absent pair pin active");
        end
    end
endmodule
bind pov_top pov_top_chk #(.NUM_PAIRS(NUM_PAIRS)) u_chk (.MCLK(MCLK), .RESETN(RESETN),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .GEN_HIGH(GEN_HIGH), .GEN_LOW(GEN_LOW),
    .PAIR_HIGH_OUTPUT_PIN(PAIR_HIGH_OUTPUT_PIN), .PAIR_LOW_OUTPUT_PIN(PAIR_LOW_OUTPUT_PIN));

// ---- pwm_output_override_control_tb.sv ----
// Bench for the override stage and its one-pair variant
module pwm_output_override_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
        $display("unexpected %s exp %h got %h", n, e, g); end end
    logic MCLK = 0, RESETN = 0, HSEL = 0, HWRITE = 0, HREADYOUT, hresp1;
    logic [31:0] HADDR = 0, HWDATA = 0, r1, r2, rd1, rd2;
    logic [1:0] HTRANS = 0;
    logic [2:0] HSIZE = 3'h2, GEN_HIGH = 0, GEN_LOW = 0, ph1, pl1, ph2, pl2;
    logic [5:0] gate;
    int n_fail = 0, checks_done = 0;
    always #2 MCLK = ~MCLK;
    pov_top uut (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRESP(hresp1), .HRDATA(rd1), .GEN_HIGH(GEN_HIGH),
        .GEN_LOW(GEN_LOW),
        .PAIR_HIGH_OUTPUT_PIN(ph1), .PAIR_LOW_OUTPUT_PIN(pl1));
    pov_top #(.NUM_PAIRS(1)) uut2 (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(), .HRESP(), .HRDATA(rd2), .GEN_HIGH(GEN_HIGH), .GEN_LOW(GEN_LOW),
        .PAIR_HIGH_OUTPUT_PIN(ph2), .PAIR_LOW_OUTPUT_PIN(pl2));
    pov_gate_drv drv (.clk(MCLK), .high_in(ph1), .low_in(pl1), .gate_q(gate));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        r1 = rd1;
        r2 = rd2;
        `CHK("hresp", 1'b0, hresp1)
    endtask
    task automatic pins(input logic [2:0] h, l, eh, el);
        @(posedge MCLK);
        GEN_HIGH <= h;
        GEN_LOW <= l;
        repeat (2) @(posedge MCLK);
        // Pins looked at mid-cycle, away from the edge that launches them
        @(negedge MCLK);
        `CHK("high pins", eh, ph1)
        `CHK("low pins", el, pl1)
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge MCLK);
        RESETN <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0000_3F00, r1)
        `CHK("ctrl 2", 32'h0000_0300, r2)
        pins(3'h5, 3'h2, 3'h5, 3'h2);
        pins(3'h2, 3'h5, 3'h2, 3'h5);
        $display("test pass-through done");
        bus(1'b1, 8'h00, 32'hFFFF_C0FF);
        bus(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0000_003F, r1)
        `CHK("ctrl 2", 32'h0000_0003, r2)
        pins(3'h0, 3'h0, 3'h7, 3'h7);
        `CHK("pair pins 2", 6'h09, {ph2, pl2})
        bus(1'b1, 8'h00, 32'h0000_152A);
        pins(3'h0, 3'h5, 3'h7, 3'h5);
        @(negedge MCLK);
        `CHK("gates", 6'h3D, gate)
        bus(1'b1, 8'h00, 32'h0000_0A00);
        pins(3'h7, 3'h7, 3'h3, 3'h0);
        bus(1'b0, 8'h04, 32'h0);
        `CHK("pin state", 32'h0000_0300, r1)
        `CHK("pin state 2", 32'h0000_0100, r2)
        bus(1'b0, 8'h08, 32'h0);
        `CHK("pairs", 32'h0000_0003, r1)
        `CHK("pairs 2", 32'h0000_0001, r2)
        $display("test manual and field order done");
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        bus(1'b0, 8'h0C, 32'h0);
        `CHK("unmapped", 32'h0, r1)
        RESETN <= 1'b0;
        repeat (2) @(posedge MCLK);
        RESETN <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0000_3F00, r1)
        $display("test unmapped and reset done");
        close_out();
    end
    initial begin
        repeat (1000) @(posedge MCLK);
        n_fail++;
        close_out();
    end
endmodule
